// ### adc_channel_range_sequencer.sv
/*
  Channel range table, multiplexer sequencer and reference selection.
  Assumes chip select and all settings are synchronous to ref_clk_in.
*/
//
// Operation
// - Multiplexer serves 4 or 8 channels; its output feeds the converter.
// - Each channel holds its own 4-bit range code setting front-end gain.
// - After reset all range codes are zero, the widest bipolar span.
// - Bipolar codes 0,1,2,3,b give 2.5 down to 0.15625 times reference.
// - Unipolar codes 5,6,7,f give 0 to 2.5 down to 0.3125 reference.
// - Manual mode: host command picks the channel that is sampled next.
// - Auto mode: channel advances on each chip-select fall after sampling.
// - Auto mode visits only enabled channels, in ascending order.
// - Total rate shared equally; per-channel rate is total over count.
// - Strap low: internal reference, driven out on the reference pin.
// - Strap high: external reference, reference pin is an input.
// - Results are 14-bit straight binary, same format on every channel.
`timescale 1ns/1ps
module adc_channel_range_sequencer #(
  parameter int NUM_CH = 8
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Host settings
  input wire adc_seq_pkg::range_write_s channel_range_select_in,
  input wire adc_seq_pkg::channel_cmd_s manual_channel_command_in,
  input wire logic auto_mode_in,
  input wire logic [adc_seq_pkg::MAX_CH-1:0] scan_enable_in,
  // Frame and conversion
  input wire logic cs_n_in,
  input wire logic [adc_seq_pkg::RES_W-1:0] conv_code_in,
  input wire logic conv_valid_in,
  // Reference strap
  input wire logic reference_source_strap_in,
  // Multiplexer
  output logic [adc_seq_pkg::CH_W-1:0] mux_sel_out,
  output adc_seq_pkg::range_info_s active_range_out,
  output logic [adc_seq_pkg::MAX_CH-1:0][adc_seq_pkg::RANGE_W-1:0] range_table_out,
  output logic sample_strobe_out,
  output logic [adc_seq_pkg::CH_W-1:0] sample_channel_out,
  output logic [adc_seq_pkg::CH_W:0] scan_count_out,
  // Results
  output adc_seq_pkg::result_s result_out,
  // Reference
  output logic ref_internal_out,
  output logic reference_io_pin_out,
  output logic reference_io_pin_oe_n_out
);

  // ************************************************
  // Helpers
  // ************************************************
  function automatic logic [adc_seq_pkg::CH_W-1:0] next_enabled(
    input logic [adc_seq_pkg::MAX_CH-1:0] mask,
    input logic [adc_seq_pkg::CH_W-1:0] cur
  );
    logic [adc_seq_pkg::CH_W-1:0] res;
    logic found;
    int idx;
    res = cur;
    found = 1'b0;
    for (int i = 1; i <= NUM_CH; i++) begin
      idx = (int'(cur) + i) % NUM_CH;
      if (!found && mask[idx]) begin
        res = adc_seq_pkg::CH_W'(idx);
        found = 1'b1;
      end
    end
    return res;
  endfunction

  function automatic logic [adc_seq_pkg::CH_W:0] count_enabled(
    input logic [adc_seq_pkg::MAX_CH-1:0] mask
  );
    logic [adc_seq_pkg::CH_W:0] n;
    n = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      n = n + {{adc_seq_pkg::CH_W{1'b0}}, mask[i]};
    end
    return n;
  endfunction

  // ************************************************
  // State
  // ************************************************
  adc_seq_pkg::seq_state_s st_reg;
  adc_seq_pkg::seq_state_s st_next;
  adc_seq_pkg::range_info_s info_dec;
  logic [adc_seq_pkg::MAX_CH-1:0] mask_eff;
  logic cs_fall;
  logic auto_entry;

  adc_range_decoder u_decoder (
    .code_in(st_reg.range[st_reg.mux_sel]),
    .info_out(info_dec)
  );

  always_comb begin
    mask_eff = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      mask_eff[i] = scan_enable_in[i];
    end
    cs_fall = st_reg.cs_n_prev && !cs_n_in;
    auto_entry = auto_mode_in && (st_reg.mode == adc_seq_pkg::MODE_MANUAL);
    st_next = st_reg;
    st_next.cs_n_prev = cs_n_in;
    st_next.mode = auto_mode_in ? adc_seq_pkg::MODE_AUTO : adc_seq_pkg::MODE_MANUAL;
    st_next.sample_strobe = 1'b0;
    st_next.info = info_dec;
    st_next.scan_count = auto_mode_in ? count_enabled(mask_eff) : 4'h1;
    st_next.ref_internal = !reference_source_strap_in;
    if (channel_range_select_in.valid && (int'(channel_range_select_in.channel) < NUM_CH)) begin
      st_next.range[channel_range_select_in.channel] = channel_range_select_in.range_code;
    end
    if (cs_fall) begin
      st_next.sample_strobe = 1'b1;
      st_next.sample_ch = st_reg.mux_sel;
    end
    if (auto_entry) begin
      st_next.mux_sel = next_enabled(mask_eff, NUM_CH - 1 > 0 ? adc_seq_pkg::CH_W'(NUM_CH - 1) : '0);
    end else if (auto_mode_in && cs_fall) begin
      st_next.mux_sel = next_enabled(mask_eff, st_reg.mux_sel);
    end else if (!auto_mode_in && manual_channel_command_in.valid
                 && (int'(manual_channel_command_in.channel) < NUM_CH)) begin
      st_next.mux_sel = manual_channel_command_in.channel;
    end
    st_next.result.valid = conv_valid_in;
    if (conv_valid_in) begin
      st_next.result.code = conv_code_in;
      st_next.result.channel = st_reg.sample_ch;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_reg <= '0;
      st_reg.range <= {adc_seq_pkg::MAX_CH{adc_seq_pkg::RANGE_RESET}};
      st_reg.mode <= adc_seq_pkg::MODE_MANUAL;
      st_reg.mux_sel <= adc_seq_pkg::CHANNEL_RESET;
      st_reg.cs_n_prev <= 1'b1;
      st_reg.ref_internal <= 1'b1;
      st_reg.scan_count <= 4'h1;
      st_reg.info <= '{1'b1, 1'b0, 3'h0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  assign mux_sel_out = st_reg.mux_sel;
  assign active_range_out = st_reg.info;
  assign range_table_out = st_reg.range;
  assign sample_strobe_out = st_reg.sample_strobe;
  assign sample_channel_out = st_reg.sample_ch;
  assign scan_count_out = st_reg.scan_count;
  assign result_out = st_reg.result;
  assign ref_internal_out = st_reg.ref_internal;
  assign reference_io_pin_out = st_reg.ref_internal;
  assign reference_io_pin_oe_n_out = !st_reg.ref_internal;

  // ************************************************
  // Assertions
  // ************************************************
  a_auto_advance: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (auto_mode_in && st_reg.mode == adc_seq_pkg::MODE_AUTO && cs_fall)
    |=> (st_reg.mux_sel == next_enabled($past(mask_eff), $past(st_reg.mux_sel))))
    else $error("auto channel did not advance");
  a_auto_enabled_only: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (auto_mode_in && cs_fall && mask_eff[st_reg.mux_sel]) |=> mask_eff[st_reg.mux_sel] || !auto_mode_in)
    else $error("auto scan left enabled set");
  a_auto_wrap: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (auto_mode_in && st_reg.mode == adc_seq_pkg::MODE_AUTO && cs_fall
     && ((mask_eff >> (int'(st_reg.mux_sel) + 1)) == '0) && mask_eff != '0)
    |=> (st_reg.mux_sel <= $past(st_reg.mux_sel)))
    else $error("no wrap to lowest channel");
  a_manual_select: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (!auto_mode_in && !auto_entry && manual_channel_command_in.valid
     && int'(manual_channel_command_in.channel) < NUM_CH)
    |=> (st_reg.mux_sel == $past(manual_channel_command_in.channel)))
    else $error("manual command ignored");
  a_sample_channel: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    cs_fall |=> (sample_strobe_out && sample_channel_out == $past(st_reg.mux_sel)))
    else $error("sample strobe or channel wrong");
  a_range_write: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (channel_range_select_in.valid && int'(channel_range_select_in.channel) < NUM_CH)
    |=> (range_table_out[$past(channel_range_select_in.channel)] == $past(channel_range_select_in.range_code)))
    else $error("range code not stored");
  a_range_decode: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (st_reg.range[st_reg.mux_sel] == adc_seq_pkg::CODE_BIP_0P15625)
    |=> (active_range_out.valid && !active_range_out.unipolar && active_range_out.gain_shift == 3'h4))
    else $error("bipolar decode wrong");
  a_uni_decode: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (st_reg.range[st_reg.mux_sel] == adc_seq_pkg::CODE_UNI_0P3125)
    |=> (active_range_out.unipolar && active_range_out.gain_shift == 3'h3))
    else $error("unipolar decode wrong");
  a_reset_range: assert property (@(posedge ref_clk_in)
    $fell(sys_rst_in) |-> (range_table_out == '0))
    else $error("range table not zero after reset");
  a_ref_internal: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !reference_source_strap_in |=> (!reference_io_pin_oe_n_out && reference_io_pin_out))
    else $error("internal reference not driven");
  a_ref_external: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    reference_source_strap_in |=> reference_io_pin_oe_n_out)
    else $error("reference pin driven in external mode");
  a_scan_count: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    auto_mode_in |=> (scan_count_out == count_enabled($past(mask_eff))))
    else $error("scan count wrong");
  a_result_pass: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    conv_valid_in |=> (result_out.valid && result_out.code == $past(conv_code_in)))
    else $error("result code altered");

  c_auto_two_steps: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (auto_mode_in && cs_fall) ##[1:20] (auto_mode_in && cs_fall));
  c_manual_then_sample: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (!auto_mode_in && manual_channel_command_in.valid) ##[1:20] cs_fall);
  c_external_ref: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    reference_source_strap_in ##1 reference_io_pin_oe_n_out);

endmodule // adc_channel_range_sequencer

// ### adc_range_decoder.sv
/*
  Combinational decoder from a 4-bit range code to span information.
  Assumes codes arrive from the range table of the sequencer.
*/
`timescale 1ns/1ps
module adc_range_decoder (
  // Code in
  input wire logic [adc_seq_pkg::RANGE_W-1:0] code_in,
  // Decoded span
  output adc_seq_pkg::range_info_s info_out
);

  always_comb begin
    info_out = '0;
    case (code_in)
      adc_seq_pkg::CODE_BIP_2P5: info_out = '{1'b1, 1'b0, 3'h0};
      adc_seq_pkg::CODE_BIP_1P25: info_out = '{1'b1, 1'b0, 3'h1};
      adc_seq_pkg::CODE_BIP_0P625: info_out = '{1'b1, 1'b0, 3'h2};
      adc_seq_pkg::CODE_BIP_0P3125: info_out = '{1'b1, 1'b0, 3'h3};
      adc_seq_pkg::CODE_BIP_0P15625: info_out = '{1'b1, 1'b0, 3'h4};
      adc_seq_pkg::CODE_UNI_2P5: info_out = '{1'b1, 1'b1, 3'h0};
      adc_seq_pkg::CODE_UNI_1P25: info_out = '{1'b1, 1'b1, 3'h1};
      adc_seq_pkg::CODE_UNI_0P625: info_out = '{1'b1, 1'b1, 3'h2};
      adc_seq_pkg::CODE_UNI_0P3125: info_out = '{1'b1, 1'b1, 3'h3};
      default: info_out = '0;
    endcase
  end

endmodule // adc_range_decoder

// ### adc_seq_pkg.sv
/*
  Shared constants and carrier types for the channel range sequencer.
  Assumes a single clock domain and a host that writes settings as plain ports.
*/
package adc_seq_pkg;

  // ************************************************
  // Sizes
  // ************************************************
  localparam int MAX_CH = 8;
  localparam int CH_W = 3;
  localparam int RANGE_W = 4;
  localparam int RES_W = 14;
  localparam int SHIFT_W = 3;

  // ************************************************
  // Reset values
  // ************************************************
  localparam logic [RANGE_W-1:0] RANGE_RESET = 4'h0;
  localparam logic [CH_W-1:0] CHANNEL_RESET = 3'h0;

  // ************************************************
  // Range codes
  // ************************************************
  localparam logic [RANGE_W-1:0] CODE_BIP_2P5 = 4'h0;
  localparam logic [RANGE_W-1:0] CODE_BIP_1P25 = 4'h1;
  localparam logic [RANGE_W-1:0] CODE_BIP_0P625 = 4'h2;
  localparam logic [RANGE_W-1:0] CODE_BIP_0P3125 = 4'h3;
  localparam logic [RANGE_W-1:0] CODE_BIP_0P15625 = 4'hb;
  localparam logic [RANGE_W-1:0] CODE_UNI_2P5 = 4'h5;
  localparam logic [RANGE_W-1:0] CODE_UNI_1P25 = 4'h6;
  localparam logic [RANGE_W-1:0] CODE_UNI_0P625 = 4'h7;
  localparam logic [RANGE_W-1:0] CODE_UNI_0P3125 = 4'hf;

  // ************************************************
  // Types
  // ************************************************
  typedef enum logic [1:0] {
    MODE_MANUAL = 2'b01,
    MODE_AUTO = 2'b10
  } scan_mode_e;

  // Span is 2.5 x reference divided by 2**gain_shift
  typedef struct packed {
    logic valid;
    logic unipolar;
    logic [SHIFT_W-1:0] gain_shift;
  } range_info_s;

  typedef struct packed {
    logic valid;
    logic [CH_W-1:0] channel;
    logic [RANGE_W-1:0] range_code;
  } range_write_s;

  typedef struct packed {
    logic valid;
    logic [CH_W-1:0] channel;
  } channel_cmd_s;

  typedef struct packed {
    logic valid;
    logic [CH_W-1:0] channel;
    logic [RES_W-1:0] code;
  } result_s;

  typedef struct packed {
    logic [MAX_CH-1:0][RANGE_W-1:0] range;
    scan_mode_e mode;
    logic [CH_W-1:0] mux_sel;
    logic cs_n_prev;
    logic sample_strobe;
    logic [CH_W-1:0] sample_ch;
    result_s result;
    logic ref_internal;
    logic [CH_W:0] scan_count;
    range_info_s info;
  } seq_state_s;

endpackage

// ### host_ctrl_model.sv
/*
  Host controller model on the far side of the sequencer: frames chip select
  and hands back converter codes. Assumes the caller holds ref_clk_in running.
*/
`timescale 1ns/1ps
module host_ctrl_model (
  // Clock
  input wire logic clk_in,
  // Frame and conversion
  output logic cs_n_out,
  output logic conv_valid_out,
  output logic [adc_seq_pkg::RES_W-1:0] conv_code_out
);
  logic [adc_seq_pkg::RES_W-1:0] last_code;

  initial begin
    cs_n_out = 1'b1;
    conv_valid_out = 1'b0;
    conv_code_out = '0;
    last_code = '0;
  end

  // ************************************************
  // One frame, chip select low for hold plus one cycles
  // ************************************************
  task automatic frame(input int hold);
    @(posedge clk_in);
    #1;
    cs_n_out = 1'b0;
    repeat (hold) @(posedge clk_in);
    #1;
    last_code = 14'($urandom);
    conv_code_out = last_code;
    conv_valid_out = 1'b1;
    @(posedge clk_in);
    #1;
    conv_valid_out = 1'b0;
    conv_code_out = ~last_code;
    cs_n_out = 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
  endtask
endmodule // host_ctrl_model

// ### testbench.sv
/*
  Self-checking bench for the channel range sequencer.
  Assumes the host model drives chip select and converter codes.
*/
`timescale 1ns/1ps
module testbench;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  adc_seq_pkg::range_write_s wr = '0;
  adc_seq_pkg::channel_cmd_s cmd = '0;
  logic auto_mode = 1'b0;
  logic [7:0] scan_en = 8'hff;
  logic strap = 1'b0;
  wire logic cs_n;
  wire logic conv_valid;
  wire logic [13:0] conv_code;
  logic [2:0] mux_sel;
  logic [2:0] samp_ch;
  logic [7:0][3:0] table_q;
  logic [7:0][3:0] model;
  logic strobe;
  logic [3:0] cnt;
  logic ref_int;
  logic ref_pin;
  logic ref_oe_n;
  logic [2:0] cur;
  adc_seq_pkg::range_info_s act;
  adc_seq_pkg::range_info_s d;
  adc_seq_pkg::result_s res;
  adc_seq_pkg::result_s last_res;
  int error_cnt = 0;
  int n_tests = 0;
  int n_strobe = 0;

  always #25 ref_clk_in = ~ref_clk_in;

  always @(posedge ref_clk_in) begin
    if (strobe === 1'b1) n_strobe <= n_strobe + 1;
    if (res.valid === 1'b1) last_res <= res;
  end

  host_ctrl_model host (.clk_in(ref_clk_in), .cs_n_out(cs_n), .conv_valid_out(conv_valid),
    .conv_code_out(conv_code));

  adc_channel_range_sequencer #(.NUM_CH(8)) dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .channel_range_select_in(wr), .manual_channel_command_in(cmd), .auto_mode_in(auto_mode),
    .scan_enable_in(scan_en), .cs_n_in(cs_n), .conv_code_in(conv_code), .conv_valid_in(conv_valid),
    .reference_source_strap_in(strap), .mux_sel_out(mux_sel), .active_range_out(act),
    .range_table_out(table_q), .sample_strobe_out(strobe), .sample_channel_out(samp_ch),
    .scan_count_out(cnt), .result_out(res), .ref_internal_out(ref_int),
    .reference_io_pin_out(ref_pin), .reference_io_pin_oe_n_out(ref_oe_n));

  // ************************************************
  // Helpers
  // ************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n = 1);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  function automatic adc_seq_pkg::range_info_s decode(input logic [3:0] c);
    case (c)
      4'h0, 4'h1, 4'h2, 4'h3: decode = {1'b1, 1'b0, c[2:0]};
      4'hb: decode = {1'b1, 1'b0, 3'h4};
      4'h5, 4'h6, 4'h7: decode = {1'b1, 1'b1, 3'(c[2:0] - 3'h5)};
      4'hf: decode = {1'b1, 1'b1, 3'h3};
      default: decode = '0;
    endcase
  endfunction

  function automatic logic [2:0] next_en(input logic [7:0] m, input logic [2:0] c);
    next_en = c;
    for (int i = 7; i >= 1; i--) if (m[3'(c + 3'(i))]) next_en = 3'(c + 3'(i));
  endfunction

  task automatic frame_chk(input logic [2:0] exp_ch);
    int n;
    n = n_strobe;
    host.frame(1 + int'($urandom % 4));
    chk("strobe_count", n_strobe - n, 1);
    chk("sample_channel", samp_ch, exp_ch);
    chk("result_channel", last_res.channel, exp_ch);
    chk("result_code", last_res.code, host.last_code);
  endtask

  task automatic give_verdict;
    if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    void'($urandom(54));
    tick(5);
    chk("range_table", table_q, 32'h0);
    chk("active_range", act, 5'h10);
    sys_rst_in = 1'b0;
    tick();
    chk("reference", {ref_int, ref_pin, ref_oe_n}, 3'b110);
    model = '0;
    cur = 3'h0;
    for (int i = 0; i < 40; i++) begin
      wr = {1'b1, (i < 16) ? cur : 3'($urandom), (i < 16) ? 4'(i) : 4'($urandom)};
      model[wr.channel] = wr.range_code;
      tick();
      wr.valid = 1'b0;
      chk("range_table", table_q, model);
      tick();
      d = decode(model[cur]);
      chk("active_range", act, d);
    end
    for (int i = 0; i < 10; i++) begin
      cmd = {1'b1, 3'($urandom)};
      cur = cmd.channel;
      tick();
      cmd.valid = 1'b0;
      chk("mux_sel", mux_sel, cur);
      frame_chk(cur);
    end
    for (int k = 0; k < 6; k++) begin
      scan_en = (k == 0) ? 8'h80 : (k == 1) ? 8'h81 : 8'($urandom) | (8'h01 << ($urandom % 8));
      auto_mode = 1'b1;
      tick();
      cur = next_en(scan_en, 3'h7);
      chk("mux_sel", mux_sel, cur);
      chk("scan_count", cnt, $countones(scan_en));
      cmd = {1'b1, ~cur};
      tick();
      cmd.valid = 1'b0;
      chk("mux_sel", mux_sel, cur);
      for (int j = 0; j < 10; j++) begin
        frame_chk(cur);
        cur = next_en(scan_en, cur);
        chk("mux_sel", mux_sel, cur);
      end
      auto_mode = 1'b0;
      tick();
    end
    strap = 1'b1;
    tick();
    chk("reference", {ref_int, ref_oe_n}, 2'b01);
    strap = 1'b0;
    tick();
    chk("reference", {ref_int, ref_pin, ref_oe_n}, 3'b110);
    sys_rst_in = 1'b1;
    tick();
    chk("range_table", table_q, 32'h0);
    chk("mux_sel", mux_sel, 3'h0);
    chk("active_range", act, 5'h10);
    sys_rst_in = 1'b0;
    tick(2);
    chk("range_table", table_q, 32'h0);
    give_verdict();
  end

  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
endmodule // testbench
